// [rtl/iomcr_defs.svh]
/*
 * Constants of the I/O module common register bank: register numbers,
 * reset values, status bits, codes and timing.
 * Assumes the Modbus engine hands over register numbers as printed.
 */
`ifndef IOMCR_DEFS_SVH
`define IOMCR_DEFS_SVH

`define IOMCR_REG_CAL_NUM     16'h0095
`define IOMCR_REG_GAP_TMO     16'h00ef
`define IOMCR_REG_POLL_RETRY  16'h00f0
`define IOMCR_REG_POLL_INTV   16'h00f1
`define IOMCR_REG_RESP_TMO    16'h00f2
`define IOMCR_REG_FWD_IN      16'h00f5
`define IOMCR_REG_FWD_OUT     16'h00f6
`define IOMCR_REG_FWD_SIZE    16'h00f7
`define IOMCR_REG_WD_PERIOD   16'h00f8
`define IOMCR_REG_TX_DELAY    16'h00f9
`define IOMCR_REG_SAVE_TIME   16'h00fa
`define IOMCR_REG_VOLTAGE     16'h00fa
`define IOMCR_REG_BRIGHT      16'h00fb
`define IOMCR_REG_PROTOCOL    16'h00fc
`define IOMCR_REG_BAUD_IDX    16'h00fd
`define IOMCR_REG_STATUS      16'h00fe
`define IOMCR_REG_FW_REV      16'h00ff
`define IOMCR_REG_MODEL_ID    16'h0100

`define IOMCR_RST_CAL_NUM     16'hffff
`define IOMCR_RST_ZERO        16'h0000
`define IOMCR_RST_BAUD_IDX    16'h0002
`define IOMCR_RST_BRIGHT      16'h007f
`define IOMCR_BRIGHT_MAX      16'h007f
`define IOMCR_CAL_DENOM       32'h0000ffff

`define IOMCR_ST_RESTART      0
`define IOMCR_ST_TIMEOUT      1
`define IOMCR_ST_KEYLOCK      4

`define IOMCR_PROTO_DF1       16'h00df

`define IOMCR_CLK_HZ          50000000
`define IOMCR_TICK_MS         10
`define IOMCR_TICKS_PER_SEC   16'd100
`define IOMCR_REPEAT_TICKS    16'd50
`define IOMCR_FLASH_TICKS     16'd25
`define IOMCR_BAUD_0          2400
`define IOMCR_BAUD_1          4800
`define IOMCR_BAUD_2          9600
`define IOMCR_BAUD_3          19200
`define IOMCR_BAUD_4          38400
`define IOMCR_BAUD_5          115200

`endif

// [rtl/iomcr_pkg.sv]
/*
 * Types of the I/O module common register bank.
 * Assumes nothing of its surroundings.
 */
package iomcr_pkg;
	typedef enum logic [2:0] {
		IOMCR_TX_IDLE  = 3'b001,
		IOMCR_TX_DELAY = 3'b010,
		IOMCR_TX_SEND  = 3'b100
	} iomcr_tx_state_type;

	typedef enum logic [1:0] {
		IOMCR_POLL_IDLE = 2'b01,
		IOMCR_POLL_WAIT = 2'b10
	} iomcr_poll_state_type;
endpackage

// [rtl/iomcr_top.sv]
/*
 * Common register bank of a serial I/O module: holding and input registers,
 * watchdog, transmit delay, gap timeout, master polling, forwarding remap,
 * keypad, display power saving and indicators.
 * Assumes a Modbus engine on core_clk presents decoded register accesses and
 * message events; keys, lock and keep-outputs straps are asynchronous pins.
 */
`timescale 1ns/1ps
`include "iomcr_defs.svh"

module iomcr_top #(
	parameter int TICK_CYCLES = `IOMCR_TICK_MS * (`IOMCR_CLK_HZ / 1000),
	parameter logic [15:0] FW_REVISION = 16'h0001,
	// arbitrary model code
	parameter logic [15:0] MODEL_ID    = 16'h0abc
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_input_space,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata_q,
	output logic             reg_ack_q,
	output logic             reg_err_q,
	input  wire logic [15:0] supply_raw,
	input  wire logic        msg_valid,
	input  wire logic        rx_char,
	input  wire logic        tx_request,
	input  wire logic        tx_done,
	input  wire logic        master_enable,
	input  wire logic        any_forced,
	input  wire logic        keep_outputs_pin,
	input  wire logic        key_lock_pin,
	input  wire logic [3:0]  keys_pin,
	input  wire logic [15:0] fwd_addr_in,
	output logic      [15:0] supply_reading_q,
	output logic             power_led_q,
	output logic             io_led_q,
	output logic             power_saver_indicator_q,
	output logic             display_on_q,
	output logic      [6:0]  display_level_q,
	output logic             outputs_off_q,
	output logic             comm_failed_q,
	output logic             tx_enable_q,
	output logic             tx_start_q,
	output logic             rx_msg_end_q,
	output logic             baud_tick_q,
	output logic             protocol_df1_q,
	output logic             poll_start_q,
	output logic             poll_fail_q,
	output logic      [3:0]  key_event_q,
	output logic             fwd_hit_q,
	output logic      [15:0] fwd_addr_out_q
);
	logic [15:0] cal_num_q, gap_tmo_q, poll_retry_q, poll_intv_q, resp_tmo_q;
	logic [15:0] fwd_in_q, fwd_out_q, fwd_size_q, wd_period_q, tx_delay_q;
	logic [15:0] save_time_q, bright_q, protocol_q, baud_idx_q;
	logic        st_restart_q, st_timeout_q;
	logic [5:0]  sync1_q, sync2_q;
	logic [3:0]  keys_s, keys_prev_q;
	logic        keep_s, lock_s;
	logic [31:0] tick_cnt_q, baud_cnt_q;
	logic        tick10;
	logic [15:0] flash_cnt_q;
	logic        flash_q;
	logic [15:0] wd_cnt_q;
	logic        wd_expire;
	logic        st_wr_hit;
	logic [15:0] tx_cnt_q, gap_cnt_q, intv_cnt_q, resp_cnt_q, retry_cnt_q;
	logic        in_msg_q;
	logic [15:0] sec_cnt_q, idle_s_q, hold_cnt_q;
	logic        saver_q;
	logic [3:0]  press;
	logic [31:0] supply_prod;
	logic [31:0] supply_quot;
	iomcr_pkg::iomcr_tx_state_type   tx_state_q;
	iomcr_pkg::iomcr_poll_state_type poll_state_q;

	function automatic logic hold_mapped(input logic [15:0] a);
		unique case (a)
			`IOMCR_REG_CAL_NUM, `IOMCR_REG_GAP_TMO, `IOMCR_REG_POLL_RETRY,
			`IOMCR_REG_POLL_INTV, `IOMCR_REG_RESP_TMO, `IOMCR_REG_FWD_IN,
			`IOMCR_REG_FWD_OUT, `IOMCR_REG_FWD_SIZE, `IOMCR_REG_WD_PERIOD,
			`IOMCR_REG_TX_DELAY, `IOMCR_REG_SAVE_TIME, `IOMCR_REG_BRIGHT,
			`IOMCR_REG_PROTOCOL, `IOMCR_REG_BAUD_IDX, `IOMCR_REG_STATUS:
				hold_mapped = 1'b1;
			default:
				hold_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] baud_div(input logic [15:0] idx);
		unique case (idx)
			16'h0000: baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_0);
			16'h0001: baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_1);
			16'h0003: baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_3);
			16'h0004: baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_4);
			16'h0005: baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_5);
			// out-of-range index falls back to the middle rate
			default:  baud_div = 32'(`IOMCR_CLK_HZ / `IOMCR_BAUD_2);
		endcase
	endfunction

	// pins cross in through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= {keep_outputs_pin, key_lock_pin, keys_pin};
			sync2_q <= sync1_q;
		end
	end
	assign keys_s = sync2_q[3:0];
	assign lock_s = sync2_q[4];
	assign keep_s = sync2_q[5];

	assign st_wr_hit = reg_wr && !reg_input_space && reg_addr == `IOMCR_REG_STATUS;

	// holding register writes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cal_num_q    <= `IOMCR_RST_CAL_NUM;
			gap_tmo_q    <= `IOMCR_RST_ZERO;
			poll_retry_q <= `IOMCR_RST_ZERO;
			poll_intv_q  <= `IOMCR_RST_ZERO;
			resp_tmo_q   <= `IOMCR_RST_ZERO;
			fwd_in_q     <= `IOMCR_RST_ZERO;
			fwd_out_q    <= `IOMCR_RST_ZERO;
			fwd_size_q   <= `IOMCR_RST_ZERO;
			wd_period_q  <= `IOMCR_RST_ZERO;
			tx_delay_q   <= `IOMCR_RST_ZERO;
			save_time_q  <= `IOMCR_RST_ZERO;
			bright_q     <= `IOMCR_RST_BRIGHT;
			protocol_q   <= `IOMCR_RST_ZERO;
			baud_idx_q   <= `IOMCR_RST_BAUD_IDX;
		end else if (reg_wr && !reg_input_space) begin
			unique case (reg_addr)
				`IOMCR_REG_CAL_NUM:    cal_num_q <= reg_wdata;
				`IOMCR_REG_GAP_TMO:    gap_tmo_q <= reg_wdata;
				`IOMCR_REG_POLL_RETRY: poll_retry_q <= reg_wdata;
				`IOMCR_REG_POLL_INTV:  poll_intv_q <= reg_wdata;
				`IOMCR_REG_RESP_TMO:   resp_tmo_q <= reg_wdata;
				`IOMCR_REG_FWD_IN:     fwd_in_q <= reg_wdata;
				`IOMCR_REG_FWD_OUT:    fwd_out_q <= reg_wdata;
				`IOMCR_REG_FWD_SIZE:   fwd_size_q <= reg_wdata;
				`IOMCR_REG_WD_PERIOD:  wd_period_q <= reg_wdata;
				`IOMCR_REG_TX_DELAY:   tx_delay_q <= reg_wdata;
				`IOMCR_REG_SAVE_TIME:  save_time_q <= reg_wdata;
				`IOMCR_REG_BRIGHT:
					bright_q <= (reg_wdata > `IOMCR_BRIGHT_MAX) ? `IOMCR_BRIGHT_MAX : reg_wdata;
				`IOMCR_REG_PROTOCOL:   protocol_q <= reg_wdata;
				`IOMCR_REG_BAUD_IDX:   baud_idx_q <= reg_wdata;
				default:               ;
			endcase
		end
	end

	// status flags: set wins over a write-one clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_restart_q <= 1'b1;
			st_timeout_q <= 1'b0;
		end else begin
			if (st_wr_hit && reg_wdata[`IOMCR_ST_RESTART])
				st_restart_q <= 1'b0;
			if (wd_expire)
				st_timeout_q <= 1'b1;
			else if (st_wr_hit && reg_wdata[`IOMCR_ST_TIMEOUT])
				st_timeout_q <= 1'b0;
		end
	end

	// register reads and access answer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_q <= `IOMCR_RST_ZERO;
			reg_ack_q   <= 1'b0;
			reg_err_q   <= 1'b0;
		end else begin
			reg_ack_q <= reg_rd || reg_wr;
			reg_err_q <= 1'b0;
			if (reg_wr)
				reg_err_q <= reg_input_space || !hold_mapped(reg_addr);
			if (reg_rd) begin
				reg_rdata_q <= `IOMCR_RST_ZERO;
				if (reg_input_space) begin
					unique case (reg_addr)
						`IOMCR_REG_VOLTAGE:  reg_rdata_q <= supply_reading_q;
						`IOMCR_REG_FW_REV:   reg_rdata_q <= FW_REVISION;
						`IOMCR_REG_MODEL_ID: reg_rdata_q <= MODEL_ID;
						default:             reg_err_q <= 1'b1;
					endcase
				end else begin
					unique case (reg_addr)
						`IOMCR_REG_CAL_NUM:    reg_rdata_q <= cal_num_q;
						`IOMCR_REG_GAP_TMO:    reg_rdata_q <= gap_tmo_q;
						`IOMCR_REG_POLL_RETRY: reg_rdata_q <= poll_retry_q;
						`IOMCR_REG_POLL_INTV:  reg_rdata_q <= poll_intv_q;
						`IOMCR_REG_RESP_TMO:   reg_rdata_q <= resp_tmo_q;
						`IOMCR_REG_FWD_IN:     reg_rdata_q <= fwd_in_q;
						`IOMCR_REG_FWD_OUT:    reg_rdata_q <= fwd_out_q;
						`IOMCR_REG_FWD_SIZE:   reg_rdata_q <= fwd_size_q;
						`IOMCR_REG_WD_PERIOD:  reg_rdata_q <= wd_period_q;
						`IOMCR_REG_TX_DELAY:   reg_rdata_q <= tx_delay_q;
						`IOMCR_REG_SAVE_TIME:  reg_rdata_q <= save_time_q;
						`IOMCR_REG_BRIGHT:     reg_rdata_q <= bright_q;
						`IOMCR_REG_PROTOCOL:   reg_rdata_q <= protocol_q;
						`IOMCR_REG_BAUD_IDX:   reg_rdata_q <= baud_idx_q;
						`IOMCR_REG_STATUS: begin
							reg_rdata_q[`IOMCR_ST_RESTART] <= st_restart_q;
							reg_rdata_q[`IOMCR_ST_TIMEOUT] <= st_timeout_q;
							reg_rdata_q[`IOMCR_ST_KEYLOCK] <= lock_s;
						end
						default:               reg_err_q <= 1'b1;
					endcase
				end
			end
		end
	end

	// scaled supply reading, register holds volts times ten
	assign supply_prod = supply_raw * cal_num_q;
	assign supply_quot = supply_prod / `IOMCR_CAL_DENOM;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			supply_reading_q <= `IOMCR_RST_ZERO;
		else
			supply_reading_q <= supply_quot[15:0];
	end

	// 10 ms time base and flash phase
	assign tick10 = tick_cnt_q == 32'(TICK_CYCLES - 1);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_q  <= 32'h0;
			flash_cnt_q <= 16'h0;
			flash_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick10 ? 32'h0 : tick_cnt_q + 32'h1;
			if (tick10) begin
				flash_cnt_q <= flash_cnt_q + 16'h1;
				if (flash_cnt_q == `IOMCR_FLASH_TICKS - 16'h1) begin
					flash_cnt_q <= 16'h0;
					flash_q     <= !flash_q;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			baud_cnt_q  <= 32'h0;
			baud_tick_q <= 1'b0;
		end else begin
			baud_tick_q <= baud_cnt_q >= baud_div(baud_idx_q) - 32'h1;
			baud_cnt_q  <= (baud_cnt_q >= baud_div(baud_idx_q) - 32'h1) ? 32'h0
			               : baud_cnt_q + 32'h1;
		end
	end

	// watchdog expiry in 10 ms steps
	assign wd_expire = tick10 && wd_period_q != 16'h0 && !comm_failed_q
	                   && !msg_valid && wd_cnt_q + 16'h1 >= wd_period_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wd_cnt_q      <= 16'h0;
			comm_failed_q <= 1'b0;
		end else if (msg_valid) begin
			wd_cnt_q      <= 16'h0;
			comm_failed_q <= 1'b0;
		end else if (wd_period_q == 16'h0) begin
			wd_cnt_q      <= 16'h0;
			comm_failed_q <= 1'b0;
		end else if (wd_expire) begin
			comm_failed_q <= 1'b1;
		end else if (tick10 && !comm_failed_q) begin
			wd_cnt_q <= wd_cnt_q + 16'h1;
		end
	end

	// transmit enable, then delay, then data start
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_state_q  <= iomcr_pkg::IOMCR_TX_IDLE;
			tx_cnt_q    <= 16'h0;
			tx_enable_q <= 1'b0;
			tx_start_q  <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			unique case (tx_state_q)
				iomcr_pkg::IOMCR_TX_IDLE: if (tx_request) begin
					tx_enable_q <= 1'b1;
					tx_cnt_q    <= 16'h0;
					tx_state_q  <= iomcr_pkg::IOMCR_TX_DELAY;
				end
				iomcr_pkg::IOMCR_TX_DELAY: begin
					if (tx_cnt_q >= tx_delay_q) begin
						tx_start_q <= 1'b1;
						tx_state_q <= iomcr_pkg::IOMCR_TX_SEND;
					end else if (tick10) begin
						tx_cnt_q <= tx_cnt_q + 16'h1;
					end
				end
				iomcr_pkg::IOMCR_TX_SEND: if (tx_done) begin
					tx_enable_q <= 1'b0;
					tx_state_q  <= iomcr_pkg::IOMCR_TX_IDLE;
				end
			endcase
		end
	end

	// gap timeout ends peer-to-peer and DF1 frames
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			in_msg_q       <= 1'b0;
			gap_cnt_q      <= 16'h0;
			rx_msg_end_q   <= 1'b0;
			protocol_df1_q <= 1'b0;
		end else begin
			protocol_df1_q <= protocol_q == `IOMCR_PROTO_DF1;
			rx_msg_end_q   <= 1'b0;
			if (rx_char) begin
				in_msg_q  <= 1'b1;
				gap_cnt_q <= 16'h0;
			end else if (in_msg_q && tick10) begin
				if (gap_cnt_q + 16'h1 > gap_tmo_q) begin
					in_msg_q     <= 1'b0;
					rx_msg_end_q <= 1'b1;
				end else begin
					gap_cnt_q <= gap_cnt_q + 16'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			poll_state_q <= iomcr_pkg::IOMCR_POLL_IDLE;
			intv_cnt_q   <= 16'h0;
			resp_cnt_q   <= 16'h0;
			retry_cnt_q  <= 16'h0;
			poll_start_q <= 1'b0;
			poll_fail_q  <= 1'b0;
		end else begin
			poll_start_q <= 1'b0;
			poll_fail_q  <= 1'b0;
			unique case (poll_state_q)
				iomcr_pkg::IOMCR_POLL_IDLE: begin
					if (!master_enable || poll_intv_q == 16'h0) begin
						intv_cnt_q <= 16'h0;
					end else if (tick10) begin
						intv_cnt_q <= intv_cnt_q + 16'h1;
						if (intv_cnt_q + 16'h1 >= poll_intv_q) begin
							intv_cnt_q   <= 16'h0;
							resp_cnt_q   <= 16'h0;
							retry_cnt_q  <= 16'h0;
							poll_start_q <= 1'b1;
							poll_state_q <= iomcr_pkg::IOMCR_POLL_WAIT;
						end
					end
				end
				iomcr_pkg::IOMCR_POLL_WAIT: begin
					if (msg_valid || !master_enable) begin
						poll_state_q <= iomcr_pkg::IOMCR_POLL_IDLE;
					end else if (tick10) begin
						resp_cnt_q <= resp_cnt_q + 16'h1;
						if (resp_cnt_q + 16'h1 >= resp_tmo_q) begin
							resp_cnt_q <= 16'h0;
							if (retry_cnt_q < poll_retry_q) begin
								retry_cnt_q  <= retry_cnt_q + 16'h1;
								poll_start_q <= 1'b1;
							end else begin
								poll_fail_q  <= 1'b1;
								poll_state_q <= iomcr_pkg::IOMCR_POLL_IDLE;
							end
						end
					end
				end
			endcase
		end
	end

	// incoming window remapped onto outgoing base
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fwd_hit_q      <= 1'b0;
			fwd_addr_out_q <= 16'h0;
		end else begin
			fwd_hit_q      <= fwd_size_q != 16'h0 && fwd_addr_in >= fwd_in_q
			                  && fwd_addr_in - fwd_in_q < fwd_size_q;
			fwd_addr_out_q <= fwd_addr_in - fwd_in_q + fwd_out_q;
		end
	end

	// keypad edges and typematic repeat
	assign press = keys_s & ~keys_prev_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			keys_prev_q <= 4'h0;
			hold_cnt_q  <= 16'h0;
			key_event_q <= 4'h0;
		end else begin
			keys_prev_q <= keys_s;
			key_event_q <= 4'h0;
			if (press != 4'h0 || keys_s == 4'h0) begin
				hold_cnt_q <= 16'h0;
				// key events drive menu navigation; wake press is swallowed
				if (!saver_q)
					key_event_q <= press;
			end else if (tick10) begin
				hold_cnt_q <= hold_cnt_q + 16'h1;
				// repeat every half second while held
				if (hold_cnt_q + 16'h1 >= `IOMCR_REPEAT_TICKS) begin
					hold_cnt_q  <= 16'h0;
					key_event_q <= keys_s;
				end
			end
		end
	end

	// display power saving
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sec_cnt_q <= 16'h0;
			idle_s_q  <= 16'h0;
			saver_q   <= 1'b0;
		end else begin
			if (tick10)
				sec_cnt_q <= (sec_cnt_q + 16'h1 >= `IOMCR_TICKS_PER_SEC) ? 16'h0
				             : sec_cnt_q + 16'h1;
			if (press != 4'h0) begin
				idle_s_q <= 16'h0;
				saver_q  <= 1'b0;
			end else if (save_time_q == 16'h0) begin
				idle_s_q <= 16'h0;
				saver_q  <= 1'b0;
			end else if (idle_s_q >= save_time_q) begin
				saver_q <= 1'b1;
			end else if (tick10 && sec_cnt_q + 16'h1 >= `IOMCR_TICKS_PER_SEC) begin
				idle_s_q <= idle_s_q + 16'h1;
			end
		end
	end

	// indicators, display and output shutdown
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			power_led_q             <= 1'b0;
			io_led_q                <= 1'b0;
			power_saver_indicator_q <= 1'b0;
			display_on_q            <= 1'b0;
			display_level_q         <= 7'h00;
			outputs_off_q           <= 1'b0;
		end else begin
			power_led_q <= 1'b1;
			// flash on timeout, else steady when forced
			io_led_q <= comm_failed_q ? flash_q : any_forced;
			power_saver_indicator_q <= saver_q && flash_q;
			display_on_q    <= !saver_q && bright_q != 16'h0;
			display_level_q <= saver_q ? 7'h00 : bright_q[6:0];
			// outputs off on communication failure unless kept by strap
			outputs_off_q <= comm_failed_q && !keep_s;
		end
	end
endmodule

// [testbench/iomcr_top_asserts.sv]
/* assertions on the ports of the common register bank
   assumes one register master and ticks many cycles long */
`timescale 1ns/1ps
module iomcr_top_checker (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_input_space,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_ack_q,
	input wire logic        reg_err_q,
	input wire logic        msg_valid,
	input wire logic        tx_request,
	input wire logic        any_forced,
	input wire logic        power_led_q,
	input wire logic        io_led_q,
	input wire logic        power_saver_indicator_q,
	input wire logic        display_on_q,
	input wire logic [6:0]  display_level_q,
	input wire logic        outputs_off_q,
	input wire logic        comm_failed_q,
	input wire logic        tx_enable_q,
	input wire logic        tx_start_q,
	input wire logic        protocol_df1_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_tx_req; tx_request && !tx_enable_q; endsequence
	sequence s_proto_wr; reg_wr && !reg_input_space && reg_addr == 16'h00fc; endsequence
	property p_ack; $past(rstn) |-> reg_ack_q == $past(reg_wr || reg_rd); endproperty
	property p_ro_wr; reg_wr && reg_input_space |=> reg_err_q; endproperty
	property p_pwr; $past(rstn) |-> power_led_q; endproperty
	property p_disp; display_on_q == (display_level_q != 7'h00); endproperty
	property p_saver; power_saver_indicator_q |-> !display_on_q; endproperty
	property p_outs; outputs_off_q |-> comm_failed_q || $past(comm_failed_q); endproperty
	property p_io; $past(rstn) && !comm_failed_q && !$past(comm_failed_q)
		|-> io_led_q == $past(any_forced); endproperty
	property p_txen; s_tx_req |=> tx_enable_q; endproperty
	property p_txst; tx_start_q |-> tx_enable_q; endproperty
	property p_df1; s_proto_wr |-> ##2 protocol_df1_q == ($past(reg_wdata, 2) == 16'h00df);
	endproperty
	property p_msg; msg_valid |=> !comm_failed_q; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after strobe");
	a_ro_wr: assert property (p_ro_wr) else $error("input space write accepted");
	a_pwr: assert property (p_pwr) else $error("power indicator dark");
	a_disp: assert property (p_disp) else $error("display on with level zero");
	a_saver: assert property (p_saver) else $error("saver lit with display on");
	a_outs: assert property (p_outs) else $error("outputs off without failure");
	a_io: assert property (p_io) else $error("io indicator not following force");
	a_txen: assert property (p_txen) else $error("transmit enable late");
	a_txst: assert property (p_txst) else $error("data start without enable");
	a_df1: assert property (p_df1) else $error("protocol flag wrong");
	a_msg: assert property (p_msg) else $error("message did not clear failure");
endmodule
bind iomcr_top iomcr_top_checker chk_u (.*);

// [testbench/iomcr_master_model.sv]
/* serial master model: decoded register accesses and message events
   assumes the answer comes exactly one cycle after the strobe */
`timescale 1ns/1ps
module iomcr_master_model (
	input  wire logic        core_clk,
	input  wire logic        reg_ack_q,
	input  wire logic        reg_err_q,
	input  wire logic [15:0] reg_rdata_q,
	output logic             reg_wr = 1'b0,
	output logic             reg_rd = 1'b0,
	output logic             reg_input_space = 1'b0,
	output logic      [15:0] reg_addr = 16'h0000,
	output logic      [15:0] reg_wdata = 16'h0000,
	output logic             msg_valid = 1'b0
);
	task automatic acc(input logic w, input logic i, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] r, output logic e);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_input_space <= i;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// released bus shows garbage, not the last word
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		r = reg_ack_q ? reg_rdata_q : 16'hxxxx;
		e = reg_err_q;
	endtask
	task automatic msg();
		@(posedge core_clk);
		msg_valid <= 1'b1;
		@(posedge core_clk);
		msg_valid <= 1'b0;
	endtask
endmodule

// [testbench/test_io_module_common_register_bank.sv]
/* self-checking bench of the common register bank
   assumes a short tick parameter and the master model on the register port */
`timescale 1ns/1ps
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin mismatches++; \
	$display("unexpected at %0t ns: got %h want %h", $time, g, w); end end
module test_io_module_common_register_bank;
	localparam int TICK = 10;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_wr, reg_rd, reg_input_space, reg_ack_q, reg_err_q, msg_valid, err;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_q, rd, d, cal, raw, supply_reading_q;
	logic [15:0] supply_raw = 16'h0000, fwd_addr_in = 16'h0000, fwd_addr_out_q;
	logic        rx_char = 1'b0, tx_request = 1'b0, tx_done = 1'b0, master_enable = 1'b0;
	logic        any_forced = 1'b0, keep_outputs_pin = 1'b0, key_lock_pin = 1'b0;
	logic [3:0]  keys_pin = 4'h0, key_event_q;
	logic [6:0]  display_level_q;
	logic        power_led_q, io_led_q, power_saver_indicator_q, display_on_q, outputs_off_q;
	logic        comm_failed_q, tx_enable_q, tx_start_q, rx_msg_end_q, baud_tick_q;
	logic        protocol_df1_q, poll_start_q, poll_fail_q, fwd_hit_q;
	logic [31:0] seed = 32'h0001_0415;
	logic [15:0] tbl [14] = '{16'h0095, 16'h00ef, 16'h00f0, 16'h00f1, 16'h00f2, 16'h00f5,
		16'h00f6, 16'h00f7, 16'h00f8, 16'h00f9, 16'h00fa, 16'h00fb, 16'h00fc, 16'h00fd};
	int          mismatches = 0, num_checks = 0, n;
	always #10 core_clk = ~core_clk;
	// model identity values are arbitrary
	iomcr_top #(.TICK_CYCLES(TICK), .FW_REVISION(16'h0002), .MODEL_ID(16'h0bcd)) dut_u (
		.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_input_space(reg_input_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q), .reg_err_q(reg_err_q),
		.supply_raw(supply_raw), .msg_valid(msg_valid), .rx_char(rx_char),
		.tx_request(tx_request), .tx_done(tx_done), .master_enable(master_enable),
		.any_forced(any_forced), .keep_outputs_pin(keep_outputs_pin),
		.key_lock_pin(key_lock_pin), .keys_pin(keys_pin), .fwd_addr_in(fwd_addr_in),
		.supply_reading_q(supply_reading_q), .power_led_q(power_led_q), .io_led_q(io_led_q),
		.power_saver_indicator_q(power_saver_indicator_q), .display_on_q(display_on_q),
		.display_level_q(display_level_q), .outputs_off_q(outputs_off_q),
		.comm_failed_q(comm_failed_q), .tx_enable_q(tx_enable_q), .tx_start_q(tx_start_q),
		.rx_msg_end_q(rx_msg_end_q), .baud_tick_q(baud_tick_q),
		.protocol_df1_q(protocol_df1_q), .poll_start_q(poll_start_q),
		.poll_fail_q(poll_fail_q), .key_event_q(key_event_q), .fwd_hit_q(fwd_hit_q),
		.fwd_addr_out_q(fwd_addr_out_q));
	iomcr_master_model m_u (.core_clk(core_clk), .reg_ack_q(reg_ack_q), .reg_err_q(reg_err_q),
		.reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_input_space(reg_input_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.msg_valid(msg_valid));
	function logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	function automatic logic [15:0] rst_val(input logic [15:0] a);
		return a == 16'h0095 ? 16'hffff : a == 16'h00fb ? 16'h007f :
			a == 16'h00fd ? 16'h0002 : 16'h0000;
	endfunction
	function automatic logic [15:0] exp_rd(input logic [15:0] a, input logic [15:0] v);
		return (a == 16'h00fb && v > 16'h007f) ? 16'h007f : v;
	endfunction
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		m_u.acc(1'b1, 1'b0, a, v, rd, err);
	endtask
	task automatic pin(input logic [3:0] k);
		@(posedge core_clk);
		keys_pin <= k;
	endtask
	task automatic stop_test();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#(20 * 20000);
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		cyc(2);
		`CHK(power_led_q, 1'b1)
		m_u.acc(1'b0, 1'b0, 16'h00fe, 16'h0000, rd, err);
		`CHK(rd & 16'h0013, 16'h0001)
		for (int i = 0; i < 14; i++) begin
			m_u.acc(1'b0, 1'b0, tbl[i], 16'h0000, rd, err);
			`CHK(rd, rst_val(tbl[i]))
			d = rnd();
			if (i == 11) d = 16'h0080;
			wr(tbl[i], d);
			m_u.acc(1'b0, 1'b0, tbl[i], 16'h0000, rd, err);
			`CHK(rd, exp_rd(tbl[i], d))
		end
		wr(16'h00f8, 16'h0000);
		wr(16'h00fa, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			wr(16'h00fc, i ? 16'h0000 : 16'h00df);
			cyc(2);
			`CHK(protocol_df1_q, i == 0)
		end
		cal = rnd();
		raw = rnd();
		wr(16'h0095, cal);
		@(posedge core_clk);
		supply_raw <= raw;
		fwd_addr_in <= 16'h0105;
		cyc(3);
		`CHK(supply_reading_q, 16'((32'(raw) * 32'(cal)) / 32'h0000ffff))
		m_u.acc(1'b0, 1'b1, 16'h00fa, 16'h0000, rd, err);
		`CHK(rd, 16'((32'(raw) * 32'(cal)) / 32'h0000ffff))
		m_u.acc(1'b0, 1'b1, 16'h0100, 16'h0000, rd, err);
		`CHK(rd, 16'h0bcd)
		m_u.acc(1'b1, 1'b1, 16'h00ff, 16'h1234, rd, err);
		`CHK(err, 1'b1)
		m_u.acc(1'b0, 1'b0, 16'h0096, 16'h0000, rd, err);
		`CHK({err, rd}, 17'h10000)
		wr(16'h00f5, 16'h0100);
		wr(16'h00f6, 16'h0200);
		wr(16'h00f7, 16'h0010);
		cyc(3);
		`CHK({fwd_hit_q, fwd_addr_out_q}, 17'h10205)
		@(posedge core_clk);
		any_forced <= 1'b1;
		wr(16'h00f8, 16'h0003);
		m_u.msg();
		cyc(18);
		`CHK(comm_failed_q, 1'b0)
		cyc(15);
		`CHK({comm_failed_q, outputs_off_q}, 2'b11)
		m_u.acc(1'b0, 1'b0, 16'h00fe, 16'h0000, rd, err);
		`CHK(rd[1], 1'b1)
		@(posedge core_clk);
		keep_outputs_pin <= 1'b1;
		key_lock_pin <= 1'b1;
		cyc(5);
		`CHK(outputs_off_q, 1'b0)
		m_u.msg();
		wr(16'h00f8, 16'h0000);
		wr(16'h00fe, 16'h0003);
		m_u.acc(1'b0, 1'b0, 16'h00fe, 16'h0000, rd, err);
		`CHK(rd & 16'h0013, 16'h0010)
		cyc(40);
		`CHK(comm_failed_q, 1'b0)
		for (int i = 0; i < 2; i++) begin
			wr(16'h00f9, 16'(2 * i));
			@(posedge core_clk);
			tx_request <= 1'b1;
			@(posedge core_clk);
			tx_request <= 1'b0;
			n = 0;
			while (tx_start_q !== 1'b1 && n < 100) begin
				cyc(1);
				n++;
			end
			`CHK(i ? (n > TICK && n <= 2 * TICK + 3) : n == 1, 1'b1)
			@(posedge core_clk);
			tx_done <= 1'b1;
			@(posedge core_clk);
			tx_done <= 1'b0;
			cyc(2);
			`CHK(tx_enable_q, 1'b0)
		end
		@(posedge core_clk);
		key_lock_pin <= 1'b0;
		wr(16'h00fa, 16'h0001);
		cyc(200 * TICK + 20);
		`CHK({display_on_q, display_level_q}, 8'h00)
		n = 0;
		repeat (60 * TICK) begin
			cyc(1);
			n += power_saver_indicator_q;
		end
		`CHK(n > 0 && n < 60 * TICK, 1'b1)
		pin(4'h1);
		cyc(6);
		`CHK(display_on_q, 1'b1)
		wr(16'h00fa, 16'h0000);
		pin(4'h0);
		cyc(4);
		pin(4'h8);
		n = 0;
		while (key_event_q[3] !== 1'b1 && n < 8) begin
			cyc(1);
			n++;
		end
		`CHK(key_event_q, 4'h8)
		n = 0;
		repeat (45 * TICK) begin
			cyc(1);
			n += key_event_q[3];
		end
		`CHK(n, 0)
		repeat (10 * TICK) begin
			cyc(1);
			n += key_event_q[3];
		end
		`CHK(n, 1)
		pin(4'h0);
		stop_test();
	end
endmodule
